//--- pkg/gtsl_pkg.sv
// package of constants and types for the gear tooth switch logic
package gtsl_pkg;
   // sample width of the processed field signal
   localparam int unsigned SIG_W           = 12;
   // clock rate and stop mode timer
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned STOP_TIME_S     = 2;
   localparam int unsigned STOP_CYCLES     = STOP_TIME_S * CLK_HZ;
   // watchdog timeout in clock cycles, value open
   localparam int unsigned WDOG_CYCLES     = 60_000_000;
   // lockout amplitude level in signal codes
   localparam logic [11:0] LOCKOUT_LEVEL   = 12'h0040;
   // target normalised peak-to-peak amplitude for gain loop
   localparam logic [11:0] GAIN_TARGET_PP  = 12'h0800;
   // mid code of the signal range for offset loop
   localparam logic [11:0] MID_CODE        = 12'h0800;
   // gain setting width and reset value
   localparam int unsigned GAIN_W          = 6;
   localparam logic [5:0]  GAIN_RESET      = 6'h20;
   // offset trim width and reset value
   localparam int unsigned OFFS_W          = 8;
   localparam logic [7:0]  OFFS_RESET      = 8'h80;
   // threshold code: 40 % plus 2 % per step, ten steps to 60 %
   localparam int unsigned THR_MIN_PCT     = 40;
   localparam int unsigned THR_STEP_PCT    = 2;
   localparam logic [3:0]  THR_MAX_CODE    = 4'h0A;
   // edges counted during calibration and to leave stop mode
   localparam logic [3:0]  CAL_EDGES       = 4'h3;
   localparam logic [3:0]  STOP_EXIT_EDGES = 4'h4;
   // operating modes
   typedef enum logic [2:0] {
      GTSL_RESET, GTSL_CAL, GTSL_RUN, GTSL_STOP
   } gtsl_mode_t;
endpackage : gtsl_pkg

//--- pkg/gtsl_peak_if.sv
// interface between the mode logic and the peak tracker
`timescale 1ns/10ps
`default_nettype none
interface gtsl_peak_if;
   logic [11:0] sample;    // processed field signal sample
   logic        track;     // tracker enable
   logic        clear;     // restart acquisition
   logic [11:0] peak_hi;   // held positive peak
   logic [11:0] peak_lo;   // held negative peak
   modport ctrl (output sample, output track, output clear,
                 input peak_hi, input peak_lo);
   modport trk  (input sample, input track, input clear,
                 output peak_hi, output peak_lo);
endinterface : gtsl_peak_if
`default_nettype wire

//--- src/gtsl_peak_track.sv
// peak-holding tracker for positive and negative peaks
`timescale 1ns/10ps
`default_nettype none
module gtsl_peak_track
   import gtsl_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   rst,
   gtsl_peak_if.trk    pk
);
   // all tracker state
   typedef struct packed {
      logic [11:0] hi;
      logic [11:0] lo;
   } gtsl_trk_t;
   gtsl_trk_t st_reg, st_next;

   // outward jumps follow at once, inward ones creep one code a sample
   // so drift is tracked without losing the peaks between teeth
   always_comb begin
      st_next = st_reg;
      if (pk.clear) begin
         st_next.hi = pk.sample;
         st_next.lo = pk.sample;
      end else if (pk.track) begin
         if (pk.sample > st_reg.hi) st_next.hi = pk.sample;
         else if (st_reg.hi > pk.sample) st_next.hi = st_reg.hi - 12'h001;
         if (pk.sample < st_reg.lo) st_next.lo = pk.sample;
         else if (st_reg.lo < pk.sample) st_next.lo = st_reg.lo + 12'h001;
      end
   end

   // register the state
   always_ff @(posedge clk) begin
      if (rst) st_reg <= '0;
      else     st_reg <= st_next;
   end

   assign pk.peak_hi = st_reg.hi;
   assign pk.peak_lo = st_reg.lo;

   // hi never below lo once tracking
   property p_order;
      @(posedge clk) disable iff (rst)
      $past(pk.track) && !$past(pk.clear) && $past(st_reg.hi >= st_reg.lo)
      |-> st_reg.hi >= st_reg.lo;
   endproperty
   a_order: assert property (p_order) else $error("peak order lost");
endmodule : gtsl_peak_track
`default_nettype wire

//--- src/gtsl_switch_logic.sv
// gear tooth switch logic: modes, thresholds, lockout, watchdog
// How it works
// - polarity 0 forward: high while tooth nearest
// - polarity 1 forward: low while tooth nearest
// - reverse rotation inverts the output sense
// - power-on over: enter calibration, acquire profile
// - output inactive until first switch point
// - calibration adjusts gain to normalise amplitude
// - offset loop centres signal with gain loop
// - after calibration run on peak-derived switch points
// - running keeps tracking peaks and offset loop
// - stop mode holds; several edges return to run
// - two peak holders; thresholds are peak percentages
// - threshold setting spans 40 to 60 percent
// - small amplitude in run freezes the output
// - no switching: watchdog restarts calibration
// - undervoltage forces power-on output state
// - two seconds without edges enters stop mode
`timescale 1ns/10ps
`default_nettype none
module gtsl_switch_logic
   import gtsl_pkg::*;
#(
   parameter int unsigned STOP_CNT = STOP_CYCLES, // stop timer cycles
   parameter int unsigned WDOG_CNT = WDOG_CYCLES, // watchdog cycles
   parameter logic        POS_LVL  = 1'b1         // power-on output level
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        power_on_done,          // power-on time over
   input  wire logic        undervoltage_threshold, // supply below minimum
   input  wire logic        sample_valid,           // new sample strobe
   input  wire logic [11:0] processed_field_signal, // processed sample
   input  wire logic        reverse_dir,            // target runs reverse
   input  wire logic        polarity,               // polarity setting
   input  wire logic [3:0]  threshold_code,         // 40 % + 2 % per step
   output logic             switch_out,             // digital output
   output logic [5:0]       automatic_gain_loop,    // gain setting
   output logic [7:0]       automatic_offset_loop,  // offset trim
   output logic [2:0]       mode_out                // current mode
);
   // all control state
   typedef struct packed {
      gtsl_mode_t  mode;
      logic        out;       // output level
      logic        active;    // first switch seen
      logic        det;       // detector: 1 above upper threshold
      logic [3:0]  edges;     // edge counter for cal and stop exit
      logic [31:0] quiet;     // cycles without edge
      logic [31:0] wdog;      // cycles without output switching
      logic [5:0]  gain;
      logic [7:0]  offs;
   } gtsl_st_t;
   gtsl_st_t st_reg, st_next;

   gtsl_peak_if pk ();
   gtsl_peak_track gtsl_peak_track_i (.clk(clk), .rst(rst), .pk(pk));

   // threshold arithmetic, hysteresis from two separate levels
   logic [11:0] pp;        // peak-to-peak
   logic [3:0]  tc;        // clamped threshold code
   logic [6:0]  pct;       // threshold percentage
   logic [18:0] frac;      // pp times percentage
   logic [11:0] thr;       // switch level above lo
   logic [11:0] thr_up;    // rising switch level
   logic [11:0] thr_dn;    // falling switch level
   logic        rise_ev;   // rising mechanical edge seen
   logic        fall_ev;   // falling mechanical edge seen
   logic        lvl;       // output level for detector state
   logic        small_sig; // amplitude in vibration band
   logic        cal_done;

   always_comb begin
      pp      = pk.peak_hi - pk.peak_lo;
      tc      = (threshold_code > THR_MAX_CODE) ? THR_MAX_CODE
                                                : threshold_code;
      pct     = 7'(THR_MIN_PCT) + 7'(THR_STEP_PCT) * {3'h0, tc};
      frac    = 19'(pp) * 19'(pct);
      thr     = 12'(frac / 19'd100);
      // hysteresis of one eighth of peak-to-peak around the level
      thr_up  = pk.peak_lo + thr + {3'h0, pp[11:3]};
      thr_dn  = pk.peak_lo + thr - {3'h0, pp[11:3]};
      rise_ev = sample_valid && !st_reg.det
                && processed_field_signal > thr_up;
      fall_ev = sample_valid && st_reg.det
                && processed_field_signal < thr_dn;
      // reverse rotation turns tooth edges round
      lvl     = (rise_ev ^ reverse_dir) ^ polarity;
      small_sig = pp < LOCKOUT_LEVEL;
      cal_done  = st_reg.edges >= CAL_EDGES;
   end

   // peak tracker steering
   always_comb begin
      pk.sample = processed_field_signal;
      pk.track  = sample_valid && (st_reg.mode == GTSL_CAL
                  || st_reg.mode == GTSL_RUN);
      pk.clear  = st_reg.mode == GTSL_RESET;
   end

   // next-state logic
   always_comb begin
      st_next = st_reg;
      case (st_reg.mode)
         GTSL_RESET: begin
            st_next.out    = POS_LVL;
            st_next.active = 1'b0;
            st_next.edges  = '0;
            st_next.quiet  = '0;
            st_next.wdog   = '0;
            if (power_on_done) st_next.mode = GTSL_CAL;
         end
         GTSL_CAL: begin
            // gain loop: grow until amplitude reaches target
            if (sample_valid && pp < GAIN_TARGET_PP
                && st_reg.gain != 6'h3F)
               st_next.gain = st_reg.gain + 6'h01;
            // offset loop: pull the mean toward mid code
            if (sample_valid && (pk.peak_hi >> 1) + (pk.peak_lo >> 1)
                > MID_CODE && st_reg.offs != 8'h00)
               st_next.offs = st_reg.offs - 8'h01;
            else if (sample_valid && (pk.peak_hi >> 1)
                     + (pk.peak_lo >> 1) < MID_CODE
                     && st_reg.offs != 8'hFF)
               st_next.offs = st_reg.offs + 8'h01;
            if (rise_ev || fall_ev) begin
               st_next.det    = rise_ev;
               st_next.out    = lvl;
               st_next.active = 1'b1;
               st_next.edges  = st_reg.edges + 4'h1;
            end
            if (cal_done) begin
               st_next.mode  = GTSL_RUN;
               st_next.edges = '0;
            end
         end
         GTSL_RUN: begin
            // offset loop stays on in running mode
            if (sample_valid && (pk.peak_hi >> 1) + (pk.peak_lo >> 1)
                > MID_CODE && st_reg.offs != 8'h00)
               st_next.offs = st_reg.offs - 8'h01;
            else if (sample_valid && (pk.peak_hi >> 1)
                     + (pk.peak_lo >> 1) < MID_CODE
                     && st_reg.offs != 8'hFF)
               st_next.offs = st_reg.offs + 8'h01;
            if ((rise_ev || fall_ev) && !small_sig) begin
               st_next.det   = rise_ev;
               st_next.out   = lvl;
               st_next.quiet = '0;
            end else if (st_reg.quiet >= STOP_CNT - 1) begin
               st_next.mode  = GTSL_STOP;
               st_next.edges = '0;
            end else begin
               st_next.quiet = st_reg.quiet + 32'h0000_0001;
            end
         end
         GTSL_STOP: begin
            // peaks frozen; detector edges still counted
            if (rise_ev || fall_ev) begin
               st_next.det   = rise_ev;
               st_next.out   = lvl;
               st_next.edges = st_reg.edges + 4'h1;
            end
            if (st_reg.edges >= STOP_EXIT_EDGES) begin
               st_next.mode  = GTSL_RUN;
               st_next.quiet = '0;
               st_next.edges = '0;
            end
         end
         default: st_next.mode = GTSL_RESET;
      endcase
      // watchdog: only in calibration and running, not in reset or a legitimate stop
      if (st_reg.mode == GTSL_RUN || st_reg.mode == GTSL_CAL) begin
         if (st_next.out != st_reg.out)
            st_next.wdog = '0;
         else if (st_reg.wdog >= WDOG_CNT - 1) begin
            st_next.mode = GTSL_RESET;
            st_next.wdog = '0;
         end else
            st_next.wdog = st_reg.wdog + 32'h0000_0001;
      end
      if (undervoltage_threshold) begin
         st_next.mode = GTSL_RESET;
         st_next.out  = POS_LVL;
      end
   end

   // register the state
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg      <= '0;
         st_reg.mode <= GTSL_RESET;
         st_reg.out  <= POS_LVL;
         st_reg.gain <= GAIN_RESET;
         st_reg.offs <= OFFS_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign switch_out            = st_reg.out;
   assign automatic_gain_loop   = st_reg.gain;
   assign automatic_offset_loop = st_reg.offs;
   assign mode_out              = st_reg.mode;

   property p_uv;
      @(posedge clk) disable iff (rst)
      undervoltage_threshold |=> switch_out == POS_LVL
                                 && mode_out == GTSL_RESET;
   endproperty
   a_uv: assert property (p_uv) else $error("uv not honoured");
   property p_inactive;
      @(posedge clk) disable iff (rst)
      !st_reg.active && st_reg.mode == GTSL_CAL |-> switch_out == POS_LVL;
   endproperty
   a_inactive: assert property (p_inactive) else $error("early out");
   property p_pol;
      @(posedge clk) disable iff (rst)
      st_reg.mode == GTSL_RUN && rise_ev && !small_sig
      && !undervoltage_threshold
      |=> switch_out == ($past(polarity) ^ $past(reverse_dir) ^ 1'b1);
   endproperty
   a_pol: assert property (p_pol) else $error("bad polarity");
   property p_lock;
      @(posedge clk) disable iff (rst)
      st_reg.mode == GTSL_RUN && small_sig && !undervoltage_threshold
      |=> $stable(switch_out);
   endproperty
   a_lock: assert property (p_lock) else $error("lockout leak");
   property p_stop;
      @(posedge clk) disable iff (rst)
      st_reg.mode == GTSL_RUN && st_reg.quiet >= STOP_CNT - 1
      && !rise_ev && !fall_ev && !undervoltage_threshold
      && st_reg.wdog < WDOG_CNT - 1 |=> mode_out == GTSL_STOP;
   endproperty
   a_stop: assert property (p_stop) else $error("no stop");
   property p_cal;
      @(posedge clk) disable iff (rst)
      st_reg.mode == GTSL_RESET && power_on_done
      && !undervoltage_threshold |=> mode_out == GTSL_CAL;
   endproperty
   a_cal: assert property (p_cal) else $error("no cal");
   property p_wdog;
      @(posedge clk) disable iff (rst)
      (st_reg.mode == GTSL_RUN || st_reg.mode == GTSL_CAL)
      && st_reg.wdog >= WDOG_CNT - 1
      && !rise_ev && !fall_ev |=> mode_out == GTSL_RESET;
   endproperty
   a_wdog: assert property (p_wdog) else $error("no watchdog");
   property p_gain;
      @(posedge clk) disable iff (rst)
      st_reg.mode != GTSL_CAL && !rst |=> $stable(automatic_gain_loop);
   endproperty
   a_gain: assert property (p_gain) else $error("gain moved");
   c_run:  cover property (@(posedge clk) mode_out == GTSL_RUN);
   c_stop: cover property (@(posedge clk) mode_out == GTSL_STOP);
   c_back: cover property (@(posedge clk)
      mode_out == GTSL_STOP ##1 mode_out == GTSL_RUN);
   // a crossing swallowed by the vibration lockout
   c_lock: cover property (@(posedge clk)
      st_reg.mode == GTSL_RUN && small_sig && rise_ev);
endmodule : gtsl_switch_logic
`default_nettype wire

//--- verif/gtsl_ecu_model.sv
// controller model that reads the switching output and counts edges
`timescale 1ns/10ps
`default_nettype none
module gtsl_ecu_model (
   input  wire logic      clk,
   input  wire logic      rst,
   input  wire logic      switch_in,
   output var  int        edges
);
   logic last_reg; // level seen at the previous clock

   // count every level change, as an edge counting input would
   always @(posedge clk) begin
      if (rst) begin
         edges    <= 0;
         last_reg <= switch_in;
      end else begin
         if (switch_in !== last_reg) edges <= edges + 1;
         last_reg <= switch_in;
      end
   end
endmodule : gtsl_ecu_model
`default_nettype wire

//--- verif/gtsl_switch_logic_tb.sv
// self-checking bench for the gear tooth switch logic
`timescale 1ns/10ps
`default_nettype none
module gtsl_switch_logic_tb
   import gtsl_pkg::*;
;
   localparam int STOP_T = 200;  // shortened stop timer
   localparam int WDOG_T = 1000; // shortened watchdog
   logic        clk  = 1'b0;     // 20 MHz clock
   logic        rst  = 1'b1;     // sync reset
   logic        pod  = 1'b0;     // power-on time over
   logic        uv   = 1'b0;     // supply low
   logic        sv   = 1'b0;     // sample strobe
   logic [11:0] sig  = 12'h0800; // sample value
   logic        rev  = 1'b0;     // reverse rotation
   logic        pol  = 1'b1;     // polarity setting
   logic [3:0]  thr  = 4'h5;     // threshold code, 50 %
   logic        sw;              // switching output
   logic [5:0]  gain;            // gain setting
   logic [7:0]  offs;            // offset trim
   logic [2:0]  mode;            // current mode
   int          edges;           // edges seen by the controller
   int          mismatches = 0;
   int          n_compared = 0;
   logic [11:0] cur = 12'h0800;  // last driven sample

   always #25 clk = ~clk;

   gtsl_switch_logic #(.STOP_CNT(STOP_T), .WDOG_CNT(WDOG_T),
      .POS_LVL(1'b1)) gtsl_switch_logic_i (
      .clk(clk), .rst(rst), .power_on_done(pod),
      .undervoltage_threshold(uv), .sample_valid(sv),
      .processed_field_signal(sig), .reverse_dir(rev), .polarity(pol),
      .threshold_code(thr), .switch_out(sw), .automatic_gain_loop(gain),
      .automatic_offset_loop(offs), .mode_out(mode));

   gtsl_ecu_model gtsl_ecu_model_i (
      .clk(clk), .rst(rst), .switch_in(sw), .edges(edges));

   // verdict and end of run
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   // single bit compare
   task automatic chk_bit(input logic got, input logic exp, input string w);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %b exp %b", $time, w, got, exp);
      end
   endtask : chk_bit

   // vector compare
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp,
                          input string w);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h exp %h", $time, w, got, exp);
      end
   endtask : chk_val

   // bounded wait for a mode; a miss ends the run
   task automatic wait_mode(input gtsl_mode_t m, input int lim);
      for (int i = 0; i < lim && mode !== m; i++) @(posedge clk) #1;
      chk_val({5'h00, mode}, {5'h00, m}, "mode");
      if (mode !== m) finish_test();
   endtask : wait_mode

   // ramp the sample in steps of 0x40, one sample a clock
   task automatic go_to(input logic [11:0] target);
      while (cur != target) begin
         @(posedge clk);
         if (cur < target) cur = cur + 12'h0040;
         else cur = cur - 12'h0040;
         sig <= cur;
         sv  <= 1'b1;
      end
      @(posedge clk);
      sv <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask : go_to

   // full swings between 0x400 and 0xC00, ending low
   task automatic wave(input int n);
      repeat (n) begin
         go_to(12'h0C00);
         go_to(12'h0400);
      end
   endtask : wave

   // reset values, calibration entry, watchdog in calibration
   task automatic t_start;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk) #1;
      chk_bit(sw, 1'b1, "power-on level");
      chk_val({2'b00, gain}, 8'h20, "gain reset");
      chk_val(offs, 8'h80, "offset reset");
      chk_val({5'h00, mode}, 8'h00, "mode reset");
      pod <= 1'b1;
      wait_mode(GTSL_CAL, 4);
      repeat (WDOG_T - 40) @(posedge clk);
      #1;
      chk_bit(sw, 1'b1, "inactive before first switch");
      chk_val({5'h00, mode}, {5'h00, GTSL_CAL}, "early watchdog");
      wait_mode(GTSL_RESET, 80);
      wait_mode(GTSL_CAL, 4);
      $display("test start done");
   endtask : t_start

   // calibration edges lead to running mode
   task automatic t_cal;
      go_to(12'h0C00);
      chk_bit(sw, 1'b0, "first switch at tooth");
      go_to(12'h0400);
      chk_bit(sw, 1'b1, "polarity 1 low side");
      wave(2);
      wait_mode(GTSL_RUN, 4);
      chk_val({2'b00, gain}, 8'h3F, "gain after calibration");
      $display("test cal done");
   endtask : t_cal

   // all polarity and direction settings
   task automatic t_polarity;
      for (int k = 0; k < 4; k++) begin
         pol <= k[0];
         rev <= k[1];
         wave(1);
         go_to(12'h0C00);
         chk_bit(sw, ~k[0] ^ k[1], "level at tooth");
         go_to(12'h0400);
         chk_bit(sw, k[0] ^ k[1], "level at valley");
      end
      $display("test polarity done");
   endtask : t_polarity

   // 40 % switches at 0x900, 60 % does not
   task automatic t_threshold;
      int e0;
      for (int k = 0; k < 2; k++) begin
         thr <= k ? 4'hA : 4'h0;
         wave(1);
         e0 = edges;
         go_to(12'h0900);
         go_to(12'h0400);
         chk_val(8'(edges - e0), k ? 8'h00 : 8'h02, "edges");
      end
      thr <= 4'h5;
      $display("test threshold done");
   endtask : t_threshold

   // quiet target enters stop, several edges return to run
   task automatic t_stop;
      // fresh edges first, so the quiet timer starts near zero
      wave(1);
      repeat (STOP_T - 60) @(posedge clk);
      #1;
      chk_val({5'h00, mode}, {5'h00, GTSL_RUN}, "early stop");
      wait_mode(GTSL_STOP, 80);
      wave(1);
      chk_val({5'h00, mode}, {5'h00, GTSL_STOP}, "early exit");
      wave(2);
      wait_mode(GTSL_RUN, 4);
      $display("test stop done");
   endtask : t_stop

   // undervoltage forces the power-on state
   task automatic t_uv;
      pol <= 1'b1;
      rev <= 1'b0;
      go_to(12'h0C00);
      chk_bit(sw, 1'b0, "before undervoltage");
      uv <= 1'b1;
      wait_mode(GTSL_RESET, 4);
      go_to(12'h0400);
      chk_bit(sw, 1'b1, "held at power-on level");
      uv <= 1'b0;
      wait_mode(GTSL_CAL, 4);
      $display("test undervoltage done");
   endtask : t_uv

   // tiny swings calibrate, then the lockout freezes the output in run
   task automatic t_lock;
      int e0;
      repeat (2) begin
         go_to(12'h0440);
         go_to(12'h0400);
      end
      wait_mode(GTSL_RUN, 4);
      e0 = edges;
      repeat (6) begin
         go_to(12'h0440);
         go_to(12'h0400);
      end
      go_to(12'h0440);
      chk_bit(sw, 1'b1, "frozen at tooth");
      chk_val(8'(edges - e0), 8'h00, "edges in lockout");
      chk_val({5'h00, mode}, {5'h00, GTSL_RUN}, "mode in lockout");
      $display("test lockout done");
   endtask : t_lock

   initial begin
      t_start();
      t_cal();
      t_polarity();
      t_threshold();
      t_stop();
      t_uv();
      t_lock();
      finish_test();
   end
endmodule : gtsl_switch_logic_tb
`default_nettype wire
